// ==== tdct_params.svh ====
// Constants for the triple down-counter timer block
`ifndef TDCT_PARAMS_SVH
`define TDCT_PARAMS_SVH
`define TDCT_CLK_HZ 25000000
`define TDCT_SLOW_HI_HZ 508000
`define TDCT_SLOW_LO_HZ 2000
`define TDCT_FAST_HZ 7372800
`define TDCT_ACC_W 26
`define TDCT_CNT_MAX 16'hFFFF
`define TDCT_CNT_RST 16'h0000
// Word offsets per timer, byte address = base * 16 + offset
`define TDCT_OFF_LOAD 4'h0
`define TDCT_OFF_VALUE 4'h4
`define TDCT_OFF_CTRL 4'h8
`define TDCT_OFF_CLEAR 4'hC
`define TDCT_BASE_T1 2'h0
`define TDCT_BASE_T2 2'h1
`define TDCT_BASE_T3 2'h2
`define TDCT_BASE_SYS 2'h3
`define TDCT_OFF_SYSCTL 4'h0
`define TDCT_OFF_ISTAT 4'h4
`define TDCT_OFF_IMASK 4'h8
// Control register bits
`define TDCT_CTRL_EN 0
`define TDCT_CTRL_PER 1
// System control bits: per slow timer {mode, clock select}
`define TDCT_SYS_T1_CSEL 0
`define TDCT_SYS_T1_MODE 1
`define TDCT_SYS_T2_CSEL 2
`define TDCT_SYS_T2_MODE 3
`define TDCT_ADR_W 6
`endif

// ==== tdct_pkg.sv ====
// Types shared by the triple down-counter timer block
package tdct_pkg;
   typedef struct packed {
      logic enable;
      logic periodic;
   } tdct_cfg_t;
   typedef enum logic {TDCT_MODE_FREE, TDCT_MODE_PERIODIC} tdct_mode_t;
endpackage

// ==== tdct_tick_gen.sv ====
// Fractional tick generator producing one-cycle strobes at a chosen rate
`timescale 1ns/1ps
`include "tdct_params.svh"
module tdct_tick_gen #(
   parameter logic [`TDCT_ACC_W-1:0] RATE_HZ = `TDCT_ACC_W'(`TDCT_FAST_HZ)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   localparam logic [`TDCT_ACC_W-1:0] CLK_HZ = `TDCT_ACC_W'(`TDCT_CLK_HZ);
   logic [`TDCT_ACC_W-1:0] acc_ff;
   logic [`TDCT_ACC_W:0] sum;
   assign sum = {1'b0, acc_ff} + {1'b0, RATE_HZ};
   // Phase accumulator keeps average rate exact without a PLL
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_ff <= '0;
         tick_o <= 1'b0;
      end else if (sum >= {1'b0, CLK_HZ}) begin
         acc_ff <= `TDCT_ACC_W'(sum - {1'b0, CLK_HZ});
         tick_o <= 1'b1;
      end else begin
         acc_ff <= sum[`TDCT_ACC_W-1:0];
         tick_o <= 1'b0;
      end
   end
endmodule

// ==== tdct_timers.sv ====
// Three 16-bit down-counting timers behind a classic Wishbone slave
// Function
// RULE1: Three timers, free-running or periodic each
// RULE2: Timers one, two count 508k or 2k
// RULE3: Slow clock, mode from system control bits
// RULE4: Per-timer control and readable 16-bit data
// RULE5: Data write loads counter immediately
// RULE6: Decrement on first tick after write
// RULE7: Underflow raises that timer's interrupt
// RULE8: Third timer fixed 7.3728 MHz clock
// RULE9: Third timer decrements next tick after update
// RULE10: Free-running underflow wraps to 0xFFFF
// RULE11: Periodic underflow reloads last written value
// RULE12: Load, value, control, clear per timer
// RULE13: Clear write drops interrupt, keeps count
// RULE14: Counts only when enabled, else holds
// RULE15: Value read has no side effect
`timescale 1ns/1ps
`include "tdct_params.svh"
module tdct_timers (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`TDCT_ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic slow_timer_one_irq_o,
   output logic slow_timer_two_irq_o,
   output logic fast_timer_three_irq_o,
   output logic irq_o
);
   logic tick_hi, tick_lo, tick_fast;
   logic [2:0] tick;
   logic [15:0] load_ff [3];
   logic [15:0] cnt_ff [3];
   tdct_pkg::tdct_cfg_t cfg_ff [3];
   logic [3:0] sysctl_ff;
   logic [2:0] pend_ff;
   logic [2:0] istat_ff;
   logic [2:0] imask_ff;
   logic [2:0] uflow;
   logic [2:0] eff_per;
   logic [2:0] load_wr, clr_wr;
   logic req, wr_acc, rd_acc;
   logic [1:0] blk;
   logic [3:0] off;
   logic [31:0] nxt_dat;

   // Two tick generators shared by both slow timers
   tdct_tick_gen #(.RATE_HZ(`TDCT_ACC_W'(`TDCT_SLOW_HI_HZ))) u_hi (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(tick_hi)
   );
   tdct_tick_gen #(.RATE_HZ(`TDCT_ACC_W'(`TDCT_SLOW_LO_HZ))) u_lo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(tick_lo)
   );
   tdct_tick_gen #(.RATE_HZ(`TDCT_ACC_W'(`TDCT_FAST_HZ))) u_fast ( // RULE8
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(tick_fast)
   );

   // CSEL set picks the 2 kHz source
   assign tick[0] = sysctl_ff[`TDCT_SYS_T1_CSEL] ? tick_lo : tick_hi; // RULE2 RULE3
   assign tick[1] = sysctl_ff[`TDCT_SYS_T2_CSEL] ? tick_lo : tick_hi; // RULE2 RULE3
   assign tick[2] = tick_fast; // RULE8 RULE9

   // Slow timer modes live in system control; its own control bit is ignored
   assign eff_per[0] = sysctl_ff[`TDCT_SYS_T1_MODE]; // RULE3
   assign eff_per[1] = sysctl_ff[`TDCT_SYS_T2_MODE]; // RULE3
   assign eff_per[2] = cfg_ff[2].periodic; // RULE1

   function automatic logic is_off(input logic [3:0] o, input logic [3:0] want);
      is_off = (o == want);
   endfunction

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_acc = req && wb_we_i;
   assign rd_acc = req && !wb_we_i;
   assign blk = wb_adr_i[5:4];
   assign off = wb_adr_i[3:0];

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_tmr
         assign load_wr[g] = wr_acc && (blk == 2'(g)) && is_off(off, `TDCT_OFF_LOAD);
         assign clr_wr[g] = wr_acc && (blk == 2'(g)) && is_off(off, `TDCT_OFF_CLEAR);
         // Underflow: enabled, tick, count at zero, not overridden by a load
         assign uflow[g] = cfg_ff[g].enable && tick[g] && !load_wr[g] &&
                           (cnt_ff[g] == 16'h0000); // RULE7 RULE14

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               load_ff[g] <= `TDCT_CNT_RST;
            end else if (load_wr[g]) begin
               load_ff[g] <= wb_dat_i[15:0]; // RULE4 RULE11
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_ff[g] <= `TDCT_CNT_RST;
            end else if (load_wr[g]) begin
               cnt_ff[g] <= wb_dat_i[15:0]; // RULE5
            end else if (uflow[g]) begin
               cnt_ff[g] <= eff_per[g] ? load_ff[g] : `TDCT_CNT_MAX; // RULE10 RULE11
            end else if (cfg_ff[g].enable && tick[g]) begin
               cnt_ff[g] <= cnt_ff[g] - 16'h0001; // RULE6 RULE9 RULE14
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cfg_ff[g] <= '0;
            end else if (wr_acc && (blk == 2'(g)) && is_off(off, `TDCT_OFF_CTRL)) begin
               cfg_ff[g].enable <= wb_dat_i[`TDCT_CTRL_EN]; // RULE4 RULE14
               cfg_ff[g].periodic <= wb_dat_i[`TDCT_CTRL_PER];
            end
         end

         // Set beats a clear landing in the same cycle
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pend_ff[g] <= 1'b0;
            end else if (uflow[g]) begin
               pend_ff[g] <= 1'b1; // RULE7
            end else if (clr_wr[g]) begin
               pend_ff[g] <= 1'b0; // RULE13
            end
         end
      end
   endgenerate

   // Sticky summary status, cleared by reading it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         istat_ff <= 3'h0;
      end else if (rd_acc && blk == `TDCT_BASE_SYS && is_off(off, `TDCT_OFF_ISTAT)) begin
         istat_ff <= uflow;
      end else begin
         istat_ff <= istat_ff | uflow;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysctl_ff <= 4'h0;
         imask_ff <= 3'h0;
      end else if (wr_acc && blk == `TDCT_BASE_SYS) begin
         if (is_off(off, `TDCT_OFF_SYSCTL) && wb_sel_i[0]) begin
            sysctl_ff <= wb_dat_i[3:0]; // RULE3
         end
         if (is_off(off, `TDCT_OFF_IMASK) && wb_sel_i[0]) begin
            imask_ff <= wb_dat_i[2:0];
         end
      end
   end

   // Read mux; value reads never touch counter or pending state
   always_comb begin
      nxt_dat = 32'h0000_0000;
      if (blk == `TDCT_BASE_SYS) begin
         unique case (off)
            `TDCT_OFF_SYSCTL: nxt_dat = {28'h0, sysctl_ff};
            `TDCT_OFF_ISTAT: nxt_dat = {29'h0, istat_ff};
            `TDCT_OFF_IMASK: nxt_dat = {29'h0, imask_ff};
            default: nxt_dat = 32'h0000_0000;
         endcase
      end else begin
         unique case (off)
            `TDCT_OFF_LOAD: nxt_dat = {16'h0, load_ff[blk]}; // RULE4 RULE12
            `TDCT_OFF_VALUE: nxt_dat = {16'h0, cnt_ff[blk]}; // RULE15
            `TDCT_OFF_CTRL: nxt_dat = {30'h0, cfg_ff[blk].periodic, cfg_ff[blk].enable};
            default: nxt_dat = 32'h0000_0000;
         endcase
      end
   end

   // One wait-free cycle answer; every address acks, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= rd_acc ? nxt_dat : 32'h0000_0000;
      end
   end

   // Per-timer lines follow pending; combined line one cycle after status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_timer_one_irq_o <= 1'b0;
         slow_timer_two_irq_o <= 1'b0;
         fast_timer_three_irq_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         slow_timer_one_irq_o <= uflow[0] | (pend_ff[0] & !clr_wr[0]); // RULE7 RULE13
         slow_timer_two_irq_o <= uflow[1] | (pend_ff[1] & !clr_wr[1]);
         fast_timer_three_irq_o <= uflow[2] | (pend_ff[2] & !clr_wr[2]);
         irq_o <= |(istat_ff & imask_ff);
      end
   end

   // Load, wrap and reload
   chk_load_takes: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      load_wr[0] |=> cnt_ff[0] == $past(wb_dat_i[15:0]))
      else $error("load not taken");

   chk_load_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      load_wr[1] |=> cnt_ff[1] == $past(wb_dat_i[15:0]))
      else $error("load two not taken");

   chk_load_three: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      load_wr[2] |=> cnt_ff[2] == $past(wb_dat_i[15:0]))
      else $error("load three not taken");

   chk_load_beats_tick: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      load_wr[2] && tick[2] |=> cnt_ff[2] == $past(wb_dat_i[15:0]))
      else $error("tick beat load");

   chk_load_kept: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
      load_wr[0] |=> load_ff[0] == $past(wb_dat_i[15:0]))
      else $error("load value not kept");

   chk_free_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      uflow[2] && !eff_per[2] |=> cnt_ff[2] == `TDCT_CNT_MAX)
      else $error("free wrap wrong");

   chk_free_wrap_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      uflow[0] && !eff_per[0] |=> cnt_ff[0] == `TDCT_CNT_MAX)
      else $error("free wrap one wrong");

   chk_free_wrap_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      uflow[1] && !eff_per[1] |=> cnt_ff[1] == `TDCT_CNT_MAX)
      else $error("free wrap two wrong");

   chk_per_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
      uflow[1] && eff_per[1] |=> cnt_ff[1] == $past(load_ff[1]))
      else $error("periodic reload wrong");

   chk_per_reload_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
      uflow[0] && eff_per[0] |=> cnt_ff[0] == $past(load_ff[0]))
      else $error("periodic reload one wrong");

   chk_per_reload_fast: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
      uflow[2] && eff_per[2] |=> cnt_ff[2] == $past(load_ff[2]))
      else $error("periodic reload three wrong");

   // Interrupt set and clear
   chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[0] |=> slow_timer_one_irq_o && pend_ff[0])
      else $error("irq not raised");

   chk_irq_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[1] |=> slow_timer_two_irq_o && pend_ff[1])
      else $error("irq two not raised");

   chk_irq_three: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[2] |=> fast_timer_three_irq_o && pend_ff[2])
      else $error("irq three not raised");

   chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[0] && clr_wr[0] |=> pend_ff[0])
      else $error("clear beat set");

   chk_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[0] |=> istat_ff[0])
      else $error("status one not set");

   chk_status_fast: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      uflow[2] |=> istat_ff[2])
      else $error("status three not set");

   chk_irq_summary: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      1'b1 |=> irq_o == $past(|(istat_ff & imask_ff)))
      else $error("combined irq wrong");

   chk_clear_drop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      clr_wr[2] && !uflow[2] && !tick[2] |=> !fast_timer_three_irq_o && $stable(cnt_ff[2]))
      else $error("clear misbehaved");

   chk_clear_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      clr_wr[0] && !uflow[0] |=> !slow_timer_one_irq_o && !pend_ff[0])
      else $error("clear one misbehaved");

   chk_clear_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      clr_wr[1] && !uflow[1] |=> !slow_timer_two_irq_o && !pend_ff[1])
      else $error("clear two misbehaved");

   // Enable and tick pacing
   chk_hold_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
      !cfg_ff[0].enable && !load_wr[0] |=> $stable(cnt_ff[0]) && !$past(uflow[0]))
      else $error("disabled timer moved");

   chk_hold_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
      !cfg_ff[1].enable && !load_wr[1] |=> $stable(cnt_ff[1]) && !$past(uflow[1]))
      else $error("disabled timer two moved");

   chk_hold_fast: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
      !cfg_ff[2].enable && !load_wr[2] |=> $stable(cnt_ff[2]) && !$past(uflow[2]))
      else $error("disabled timer three moved");

   chk_dec_tick: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      cfg_ff[2].enable && tick[2] && !load_wr[2] && cnt_ff[2] != 16'h0000
      |=> cnt_ff[2] == $past(cnt_ff[2]) - 16'h0001)
      else $error("decrement wrong");

   chk_dec_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      cfg_ff[0].enable && tick[0] && !load_wr[0] && cnt_ff[0] != 16'h0000
      |=> cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001)
      else $error("decrement one wrong");

   chk_dec_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      cfg_ff[1].enable && tick[1] && !load_wr[1] && cnt_ff[1] != 16'h0000
      |=> cnt_ff[1] == $past(cnt_ff[1]) - 16'h0001)
      else $error("decrement two wrong");

   chk_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      tick_fast |=> !tick_fast ##[1:3] tick_fast)
      else $error("fast tick rate wrong");

   chk_hi_rate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
      tick_hi |=> !tick_hi [*8])
      else $error("508k tick too fast");

   chk_lo_rate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
      tick_lo |=> !tick_lo [*8])
      else $error("2k tick too fast");

   // Bus side
   chk_read_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
      rd_acc && off == `TDCT_OFF_VALUE && blk == 2'h1 && !cfg_ff[1].enable
      |=> $stable(cnt_ff[1]) ##1 wb_ack_o == 1'b0)
      else $error("value read disturbed");

   chk_ack_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
      req |=> wb_ack_o)
      else $error("request not acked");

   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   chk_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
endmodule

// ==== tb.sv ====
// Self-checking bench for the triple down-counter timer block
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [5:0] wb_adr_i = 6'h00;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:1] t_irq;
   logic irq_o;
   int err_count = 0;
   int n_tests = 0;
   int cyc_n = 0;
   logic [31:0] seed = 32'hD164CAEA;
   logic [31:0] rd;
   logic [31:0] hold;
   logic [15:0] v;
   logic p;

   tdct_timers dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_timer_one_irq_o(t_irq[1]),
      .slow_timer_two_irq_o(t_irq[2]), .fast_timer_three_irq_o(t_irq[3]), .irq_o(irq_o));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Just after a wrap the count sits near the top
   function automatic logic [31:0] near_top(input logic [31:0] r);
      return {31'h0, r[15:0] >= 16'hFF00};
   endfunction

   function automatic logic [31:0] le(input logic [31:0] r, input logic [15:0] lim);
      return {31'h0, r[15:0] <= lim};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Request holds until ack is sampled high at a rising edge
   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t bus ack missing", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wait_pin(input int s, input int lim, output logic pin);
      int n;
      n = 0;
      pin = 1'b0;
      while (pin !== 1'b1 && n < lim) begin
         @(negedge clk_i);
         n++;
         pin = t_irq[s];
      end
   endtask

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 40000) begin
         err_count++;
         $display("[FAIL] %0t run did not finish", $time);
         test_done();
      end
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 6'h24, 32'h0, rd);
      check(rd, 32'h0);
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            v = (k == 0) ? 16'hFFFF : seed[15:0];
            wb(1'b1, {i[1:0], 4'h0}, {16'h0, v}, rd);
            wb(1'b0, {i[1:0], 4'h4}, 32'h0, rd);
            check(rd, {16'h0, v});
            wb(1'b0, {i[1:0], 4'h0}, 32'h0, rd);
            check(rd, {16'h0, v});
         end
      end
      repeat (60) @(posedge clk_i);
      wb(1'b0, 6'h24, 32'h0, rd);
      check(rd, {16'h0, v});
      check({29'h0, t_irq}, 32'h0);
      wb(1'b0, 6'h3C, 32'h0, rd);
      check(rd, 32'h0);
      // Fast timer, free-running wrap
      wb(1'b1, 6'h20, 32'h3, rd);
      wb(1'b1, 6'h28, 32'h1, rd);
      wait_pin(3, 60, p);
      check({31'h0, p}, 32'h1);
      wb(1'b0, 6'h24, 32'h0, rd);
      check(near_top(rd), 32'h1);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, 6'h28, 32'h0, rd);
      wb(1'b1, 6'h38, 32'h4, rd);
      @(negedge clk_i);
      check({31'h0, irq_o}, 32'h1);
      wb(1'b0, 6'h34, 32'h0, rd);
      check(rd & 32'h7, 32'h4);
      @(negedge clk_i);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b0, 6'h34, 32'h0, rd);
      check(rd & 32'h7, 32'h0);
      wb(1'b0, 6'h24, 32'h0, hold);
      wb(1'b1, 6'h2C, 32'h0, rd);
      @(negedge clk_i);
      check({31'h0, t_irq[3]}, 32'h0);
      wb(1'b0, 6'h24, 32'h0, rd);
      check(rd, hold);
      // Fast timer, periodic reload
      wb(1'b1, 6'h20, 32'h5, rd);
      wb(1'b1, 6'h28, 32'h3, rd);
      wait_pin(3, 80, p);
      check({31'h0, p}, 32'h1);
      wb(1'b0, 6'h24, 32'h0, rd);
      check(le(rd, 16'h0005), 32'h1);
      wb(1'b1, 6'h28, 32'h0, rd);
      // Slow timers: one periodic at 508 kHz, two free at 2 kHz
      wb(1'b1, 6'h30, 32'h6, rd);
      wb(1'b1, 6'h00, 32'h3, rd);
      wb(1'b1, 6'h10, 32'h0, rd);
      wb(1'b1, 6'h08, 32'h1, rd);
      wb(1'b1, 6'h18, 32'h1, rd);
      wait_pin(1, 400, p);
      check({31'h0, p}, 32'h1);
      wb(1'b0, 6'h04, 32'h0, rd);
      check(le(rd, 16'h0003), 32'h1);
      wait_pin(2, 14000, p);
      check({31'h0, p}, 32'h1);
      wb(1'b0, 6'h14, 32'h0, rd);
      check(near_top(rd), 32'h1);
      test_done();
   end
endmodule
